/* design/hiw_pkg.sv */
// Purpose: Constants and types of the halt, idle and wake-up controller.
// Assumes: Eight-bit register port, eight port A pins, four interrupts.
// Notes: Register offsets are word indices on the plain register port.
//
// Summary of operation
// - Halt, idle set, keep-on clear: clock-off idle.
// - Halt, idle and keep-on set: clock-on idle.
// - Low-power modes freeze memory, registers, ports.
// - Halt into idle clears watchdog, counting resumes.
// - Halt sets power-down flag, clears time-out flag.
// - Wake on port A fall, interrupt, overflow.
// - Sleeping overflow sets time-out, resets PC/SP.
// - Power-down flag: clear-watchdog clears, halt sets.
// - Per-pin port A wake enable bits.
// - Port A wake resumes after halt.
// - Disabled interrupt or full stack: resume after halt.
// - Enabled interrupt, stack free: immediate interrupt response.
// - Interrupt pending before halt cannot wake.
// - Watchdog on sub clock, divider 2^8..2^18.
// - Watchdog always counts, cannot be stopped.
// - Watchdog control resets to 01010011B, kept asleep.
// - Halt with idle clear: sleep, time base off.
// - Bad enable field resets after 2-3 sub ticks.
// - Clear-watchdog and halt instructions clear counter in software.

package hiw_pkg;

   // Register port geometry.
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int PA_W = 8;
   localparam int IRQ_W = 4;

   // Register offsets.
   localparam logic [2:0] OFS_SYSTEM_MODE = 3'h0;
   localparam logic [2:0] OFS_CTRL = 3'h1;
   localparam logic [2:0] OFS_WDOG_CTRL = 3'h2;
   localparam logic [2:0] OFS_PA_WAKE = 3'h3;
   localparam logic [2:0] OFS_STATUS = 3'h4;

   // Field positions.
   localparam int IDLE_ENABLE_BIT = 0;
   localparam int KEEP_ON_BIT = 7;
   localparam int PDF_BIT = 0;
   localparam int TO_BIT = 1;
   localparam int WEN_LSB = 3;
   localparam int WEN_MSB = 7;
   localparam int TSEL_LSB = 0;
   localparam int TSEL_MSB = 2;
   localparam int MODE_LSB = 4;

   // Values after reset.
   localparam logic [7:0] WDOG_CTRL_RST = 8'h53;
   localparam logic [7:0] PA_WAKE_RST = 8'h00;

   // Watchdog enable codes.
   localparam logic [4:0] WEN_CODE_A = 5'h15;
   localparam logic [4:0] WEN_CODE_B = 5'h0A;

   // Sub clock ticks of enable-field debounce.
   localparam logic [1:0] DEBOUNCE_TICKS = 2'h2;

   // Watchdog counter width, the longest divider exponent.
   localparam int WDOG_W = 18;

   // Operating modes.
   typedef enum logic [2:0] {
      MODE_RUN,
      MODE_SLEEP,
      MODE_IDLE_OFF,
      MODE_IDLE_ON
   } hiw_mode_e;

endpackage

/* design/hiw_sync.sv */
// Purpose: Two flip-flop synchroniser for a group of pin levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/10ps
`default_nettype none

module hiw_sync
#(
   parameter int W = 1
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Levels in and out.
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   // Both stages held together.
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } hiw_sync_s;

   hiw_sync_s st_reg;
   hiw_sync_s st_next;

   // Shift the pin level through both stages.
   always_comb
   begin
      st_next = st_reg;
      st_next.meta = d_i;
      st_next.stable = st_reg.meta;
   end

   // Register the stages.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q_o = st_reg.stable;

endmodule
`default_nettype wire

/* design/hiw_wdog_count.sv */
// Purpose: Watchdog counter stepped by sub clock ticks.
// Assumes: Tick is a one-cycle pulse per sub clock period.
// Notes: Overflow is a one-cycle pulse; the counter restarts at zero.

`timescale 1ns/10ps
`default_nettype none

module hiw_wdog_count
   import hiw_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Count control.
   input wire logic tick_i,
   input wire logic clear_i,
   input wire logic [2:0] sel_i,
   // Overflow pulse.
   output logic ovf_o
);

   // Counter and overflow pulse.
   typedef struct packed {
      logic [WDOG_W-1:0] cnt;
      logic ovf;
   } hiw_wdog_s;

   hiw_wdog_s st_reg;
   hiw_wdog_s st_next;
   logic [WDOG_W-1:0] last; // Final count of the chosen period.

   // Map the select code to the last count before overflow.
   always_comb
   begin
      unique case (sel_i)
         3'h0: last = 18'h000FF;
         3'h1: last = 18'h003FF;
         3'h2: last = 18'h00FFF;
         3'h3: last = 18'h03FFF;
         3'h4: last = 18'h07FFF;
         3'h5: last = 18'h0FFFF;
         3'h6: last = 18'h1FFFF;
         3'h7: last = 18'h3FFFF;
      endcase
   end

   // Count ticks; no input stops counting, only clear restarts it.
   always_comb
   begin
      st_next = st_reg;
      st_next.ovf = 1'b0;
      if (clear_i)
      begin
         st_next.cnt = '0;
      end
      else if (tick_i)
      begin
         if (st_reg.cnt >= last)
         begin
            st_next.cnt = '0;
            st_next.ovf = 1'b1;
         end
         else
         begin
            st_next.cnt = st_reg.cnt + 18'h00001;
         end
      end
   end

   // Register the counter.
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign ovf_o = st_reg.ovf;

endmodule
`default_nettype wire

/* design/hiw_halt_wake.sv */
// Purpose: Halt entry, low-power modes, wake-up and watchdog control.
// Assumes: Core pulses halt and clear-watchdog for one cycle each.
// Notes: Sub clock and port A arrive as pins and are synchronised.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.

`timescale 1ns/10ps
`default_nettype none

module hiw_halt_wake
   import hiw_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Register port.
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   // Core instruction events.
   input wire logic HALT_I,
   input wire logic CLEAR_WATCHDOG_INSTRUCTION_I,
   // Interrupt requests, enables and stack state.
   input wire logic [IRQ_W-1:0] IRQ_REQ_I,
   input wire logic [IRQ_W-1:0] IRQ_EN_I,
   input wire logic STACK_FULL_I,
   // Pins: slow oscillator output and port A.
   input wire logic SUB_CLK_I,
   input wire logic [PA_W-1:0] PORT_A_I,
   // Clock gating and core hold.
   output logic SYSCLK_EN_O,
   output logic TIMEBASE_EN_O,
   output logic CORE_HOLD_O,
   // Wake and reset actions.
   output logic RESUME_O,
   output logic INT_RESPONSE_O,
   output logic PC_SP_RESET_O,
   output logic DEVICE_RESET_O
);

   ////////////////////////////////////////////////////////////////////////
   // State.

   // All controller state.
   typedef struct packed {
      hiw_mode_e mode;
      logic idle_enable;
      logic sysclk_keep_on;
      logic [7:0] watchdog_control_register;
      logic [PA_W-1:0] port_a_wake_enable;
      logic power_down_flag;
      logic watchdog_timeout_flag;
      logic [IRQ_W-1:0] irq_masked;
      logic [PA_W-1:0] pa_prev;
      logic sub_prev;
      logic [1:0] bad_cnt;
      logic wake_pa;
      logic wake_irq;
      logic wake_wdt;
      logic [DATA_W-1:0] rdata;
      logic resume;
      logic int_resp;
      logic pcsp_rst;
      logic dev_rst;
   } hiw_state_s;

   hiw_state_s st_reg;
   hiw_state_s st_next;

   logic sub_s; // Synchronised sub clock level.
   logic [PA_W-1:0] pa_s; // Synchronised port A levels.
   logic sub_tick; // One cycle per sub clock rising edge.
   logic wdt_clear; // Restart of the watchdog counter.
   logic wdt_ovf; // Watchdog overflow pulse.
   logic [PA_W-1:0] pa_fall; // Enabled falling edges on port A.
   logic [IRQ_W-1:0] irq_new; // Requests not pending at halt.
   logic enable_ok; // Enable field holds a valid code.
   logic asleep; // Any low-power mode.

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and watchdog counter.

   // The slow oscillator is a pin, so it is synchronised first.
   hiw_sync #(.W(1)) u_sub_sync
   (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .d_i(SUB_CLK_I),
      .q_o(sub_s)
   );

   // Port A levels pass two flip-flops before edge detection.
   hiw_sync #(.W(PA_W)) u_pa_sync
   (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .d_i(PORT_A_I),
      .q_o(pa_s)
   );

   // Watchdog counter stepped by the sub clock only.
   hiw_wdog_count u_wdog
   (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .tick_i(sub_tick),
      .clear_i(wdt_clear),
      .sel_i(st_reg.watchdog_control_register[TSEL_MSB:TSEL_LSB]),
      .ovf_o(wdt_ovf)
   );

   ////////////////////////////////////////////////////////////////////////
   // Event decode.

   // Edges, enable check and the watchdog restart sources.
   always_comb
   begin
      asleep = (st_reg.mode != MODE_RUN);
      sub_tick = sub_s & ~st_reg.sub_prev;
      pa_fall = st_reg.pa_prev & ~pa_s & st_reg.port_a_wake_enable;
      irq_new = IRQ_REQ_I & ~st_reg.irq_masked;
      enable_ok = (st_reg.watchdog_control_register[WEN_MSB:WEN_LSB] == WEN_CODE_A) ||
                  (st_reg.watchdog_control_register[WEN_MSB:WEN_LSB] == WEN_CODE_B);
      // Halt, the clear instruction and a field reset restart the count.
      wdt_clear = (HALT_I && !asleep) || CLEAR_WATCHDOG_INSTRUCTION_I || st_reg.dev_rst;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state.

   // Registers, mode sequencing, flags and wake handling.
   always_comb
   begin
      st_next = st_reg;
      st_next.sub_prev = sub_s;
      st_next.pa_prev = pa_s;
      st_next.resume = 1'b0;
      st_next.int_resp = 1'b0;
      st_next.pcsp_rst = 1'b0;
      st_next.dev_rst = 1'b0;
      st_next.rdata = '0;

      // Register writes.
      if (WR_I)
      begin
         unique case (ADDR_I)
            OFS_SYSTEM_MODE: st_next.idle_enable = WDATA_I[IDLE_ENABLE_BIT];
            OFS_CTRL: st_next.sysclk_keep_on = WDATA_I[KEEP_ON_BIT];
            OFS_WDOG_CTRL: st_next.watchdog_control_register = WDATA_I;
            OFS_PA_WAKE: st_next.port_a_wake_enable = WDATA_I;
            default:
            begin
               // Status and unmapped offsets ignore writes.
            end
         endcase
      end

      // Register reads, returned in the next cycle.
      if (RD_I)
      begin
         unique case (ADDR_I)
            OFS_SYSTEM_MODE:
               st_next.rdata[IDLE_ENABLE_BIT] = st_reg.idle_enable;
            OFS_CTRL: st_next.rdata[KEEP_ON_BIT] = st_reg.sysclk_keep_on;
            OFS_WDOG_CTRL: st_next.rdata = st_reg.watchdog_control_register;
            OFS_PA_WAKE: st_next.rdata = st_reg.port_a_wake_enable;
            OFS_STATUS:
            begin
               st_next.rdata[PDF_BIT] = st_reg.power_down_flag;
               st_next.rdata[TO_BIT] = st_reg.watchdog_timeout_flag;
               st_next.rdata[MODE_LSB+2:MODE_LSB] = st_reg.mode;
            end
            default:
            begin
               // Unmapped offsets read as zero.
            end
         endcase
      end

      // Bad enable field: count the debounce ticks, reset on the next.
      // Resetting on the tick after the debounce count gives two to three
      // sub clock periods from the bad write, never less.
      if (enable_ok)
      begin
         st_next.bad_cnt = '0;
      end
      else if (sub_tick)
      begin
         if (st_reg.bad_cnt == DEBOUNCE_TICKS)
         begin
            st_next.bad_cnt = '0;
            st_next.dev_rst = 1'b1;
            st_next.watchdog_control_register = WDOG_CTRL_RST;
            st_next.mode = MODE_RUN;
         end
         else
         begin
            st_next.bad_cnt = st_reg.bad_cnt + 2'h1;
         end
      end

      // The clear instruction clears the power-down flag.
      if (CLEAR_WATCHDOG_INSTRUCTION_I)
      begin
         st_next.power_down_flag = 1'b0;
      end

      unique case (st_reg.mode)
         MODE_RUN:
         begin
            if (HALT_I)
            begin
               // Core state freezes while the mode is not run.
               st_next.power_down_flag = 1'b1;
               st_next.watchdog_timeout_flag = 1'b0;
               st_next.irq_masked = IRQ_REQ_I;
               st_next.wake_pa = 1'b0;
               st_next.wake_irq = 1'b0;
               st_next.wake_wdt = 1'b0;
               if (!st_reg.idle_enable)
               begin
                  st_next.mode = MODE_SLEEP;
               end
               else if (!st_reg.sysclk_keep_on)
               begin
                  st_next.mode = MODE_IDLE_OFF;
               end
               else
               begin
                  st_next.mode = MODE_IDLE_ON;
               end
            end
            else if (wdt_ovf)
            begin
               // Overflow while running resets the whole device.
               st_next.watchdog_timeout_flag = 1'b1;
               st_next.dev_rst = 1'b1;
            end
         end
         default:
         begin
            // Any low-power mode: gather wake causes.
            if (|pa_fall)
            begin
               st_next.wake_pa = 1'b1;
            end
            if (|irq_new)
            begin
               st_next.wake_irq = 1'b1;
            end
            if (wdt_ovf)
            begin
               st_next.wake_wdt = 1'b1;
               st_next.watchdog_timeout_flag = 1'b1;
            end
            // Restart the core only on a sub clock tick.
            if (sub_tick &&
                (st_reg.wake_pa || st_reg.wake_irq || st_reg.wake_wdt))
            begin
               st_next.mode = MODE_RUN;
               if (st_reg.wake_wdt)
               begin
                  // Watchdog control is left as it was.
                  st_next.pcsp_rst = 1'b1;
               end
               else if (st_reg.wake_irq &&
                        |(IRQ_REQ_I & IRQ_EN_I) && !STACK_FULL_I)
               begin
                  st_next.int_resp = 1'b1;
               end
               else
               begin
                  st_next.resume = 1'b1;
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   // Power-up clears both flags and loads the watchdog control value.
   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         st_reg <= '0;
         st_reg.mode <= MODE_RUN;
         st_reg.watchdog_control_register <= WDOG_CTRL_RST;
         st_reg.port_a_wake_enable <= PA_WAKE_RST;
         st_reg.power_down_flag <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Clock gates follow the mode; core holds while not running.
   assign SYSCLK_EN_O = (st_reg.mode == MODE_RUN) ||
                        (st_reg.mode == MODE_IDLE_ON);
   assign TIMEBASE_EN_O = (st_reg.mode != MODE_SLEEP);
   assign CORE_HOLD_O = asleep;
   assign RDATA_O = st_reg.rdata;
   assign RESUME_O = st_reg.resume;
   assign INT_RESPONSE_O = st_reg.int_resp;
   assign PC_SP_RESET_O = st_reg.pcsp_rst;
   assign DEVICE_RESET_O = st_reg.dev_rst;

endmodule
`default_nettype wire

/* tb/hiw_halt_wake_props.sv */
// Purpose: Port checks of the halt, idle and wake-up controller.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Bound to every instance of the top module.

`timescale 1ns/10ps
`default_nettype none

module hiw_halt_wake_props
   import hiw_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Core side inputs.
   input wire logic HALT_I,
   input wire logic [IRQ_W-1:0] IRQ_REQ_I,
   input wire logic [IRQ_W-1:0] IRQ_EN_I,
   input wire logic STACK_FULL_I,
   // Outputs under watch.
   input wire logic SYSCLK_EN_O,
   input wire logic TIMEBASE_EN_O,
   input wire logic CORE_HOLD_O,
   input wire logic RESUME_O,
   input wire logic INT_RESPONSE_O,
   input wire logic PC_SP_RESET_O,
   input wire logic DEVICE_RESET_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);

   // Any of the three restart actions.
   wire logic act = RESUME_O | INT_RESPONSE_O | PC_SP_RESET_O;

   a_halt_enters: assert property (
      HALT_I && !CORE_HOLD_O |=> CORE_HOLD_O)
      else $error("halt did not hold the core");
   a_clock_gate: assert property (!SYSCLK_EN_O |-> CORE_HOLD_O)
      else $error("system clock off while running");
   a_timebase_off: assert property (
      !TIMEBASE_EN_O |-> CORE_HOLD_O && !SYSCLK_EN_O)
      else $error("time base off outside sleep");
   a_hold_stays: assert property ($fell(CORE_HOLD_O) |-> act)
      else $error("core released without a wake action");
   a_act_release: assert property (
      act |-> !CORE_HOLD_O && $past(CORE_HOLD_O))
      else $error("wake action outside a wake-up");
   a_one_action: assert property (
      $onehot0({RESUME_O, INT_RESPONSE_O, PC_SP_RESET_O}))
      else $error("more than one wake action");
   a_int_ok: assert property (
      INT_RESPONSE_O |-> !$past(STACK_FULL_I) &&
      ($past(IRQ_REQ_I) & $past(IRQ_EN_I)) != '0)
      else $error("interrupt response without enabled request");
   a_pulse_short: assert property (DEVICE_RESET_O |=> !DEVICE_RESET_O)
      else $error("device reset longer than one cycle");

   c_int: cover property (INT_RESPONSE_O);
   c_pcsp: cover property (PC_SP_RESET_O);
   c_dev: cover property (DEVICE_RESET_O);
endmodule

bind hiw_halt_wake hiw_halt_wake_props u_hiw_halt_wake_props (.CLK_I, .NRST_I,
   .HALT_I, .IRQ_REQ_I, .IRQ_EN_I, .STACK_FULL_I, .SYSCLK_EN_O, .TIMEBASE_EN_O,
   .CORE_HOLD_O, .RESUME_O, .INT_RESPONSE_O, .PC_SP_RESET_O, .DEVICE_RESET_O);

`default_nettype wire

/* tb/hiw_halt_wake_bench.sv */
// Purpose: Self-checking bench of the halt, idle and wake-up controller.
// Assumes: The sub clock runs free here at one eighth of the core rate.
// Notes: Port A idles high; wake pins are pulled low on purpose.

`timescale 1ns/10ps
`default_nettype none

module hiw_halt_wake_bench
   import hiw_pkg::*;
   ;
   // One row: mode setup, wake source, expected gating, status, action.
   typedef struct {
      logic [7:0] mode_v, ctrl_v;
      bit port;
      logic [3:0] en;
      logic full;
      logic [7:0] gate, st;
      int k;
   } hiw_bench_row_s;
   hiw_bench_row_s rows [5] = '{'{8'h00, 8'h00, 1, 4'h0, 0, 8'h01, 8'h11, 0},
      '{8'h01, 8'h00, 0, 4'hF, 0, 8'h03, 8'h21, 1},
      '{8'h01, 8'h80, 0, 4'h0, 0, 8'h07, 8'h31, 0},
      '{8'h00, 8'h80, 0, 4'hF, 1, 8'h01, 8'h11, 0},
      '{8'h01, 8'h80, 1, 4'h0, 0, 8'h07, 8'h31, 0}};
   logic CLK_I = 0, NRST_I = 0, WR_I = 0, RD_I = 0, HALT_I = 0;
   logic CLEAR_WATCHDOG_INSTRUCTION_I = 0, STACK_FULL_I = 0, SUB_CLK_I = 0;
   logic [ADDR_W-1:0] ADDR_I = '0;
   logic [DATA_W-1:0] WDATA_I = '0, RDATA_O;
   logic [IRQ_W-1:0] IRQ_REQ_I = '0, IRQ_EN_I = '0;
   logic [PA_W-1:0] PORT_A_I = 8'hFF;
   logic SYSCLK_EN_O, TIMEBASE_EN_O, CORE_HOLD_O, RESUME_O;
   logic INT_RESPONSE_O, PC_SP_RESET_O, DEVICE_RESET_O;
   int err_count = 0, comparisons = 0, dev_cnt = 0, sub_cnt = 0;
   // Action pulses by index and the three gating outputs side by side.
   wire logic [3:0] act = {DEVICE_RESET_O, PC_SP_RESET_O, INT_RESPONSE_O,
      RESUME_O};
   wire logic [7:0] gates = {5'h00, SYSCLK_EN_O, TIMEBASE_EN_O, CORE_HOLD_O};

   hiw_halt_wake u_hiw_halt_wake (.CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I,
      .RD_I, .RDATA_O, .HALT_I, .CLEAR_WATCHDOG_INSTRUCTION_I, .IRQ_REQ_I, .IRQ_EN_I,
      .STACK_FULL_I, .SUB_CLK_I, .PORT_A_I, .SYSCLK_EN_O, .TIMEBASE_EN_O,
      .CORE_HOLD_O, .RESUME_O, .INT_RESPONSE_O, .PC_SP_RESET_O,
      .DEVICE_RESET_O);

   // Core clock, 4 ns period.
   initial
   begin
      forever #2 CLK_I = ~CLK_I;
   end

   // Free-running sub clock and a count of device reset pulses.
   always @(posedge CLK_I)
   begin
      sub_cnt <= sub_cnt + 1;
      SUB_CLK_I <= sub_cnt[2];
      if (DEVICE_RESET_O === 1'b1)
         dev_cnt <= dev_cnt + 1;
   end

   // Compares a seen value with an expected one.
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task stop_test;
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Waits a number of rising clock edges.
   task tick(input int n);
      repeat (n) @(posedge CLK_I);
   endtask

   // One-cycle register write.
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask

   // One-cycle register read; data is taken in the following cycle.
   // The task returns on a rising edge so later drives stay edge-aligned.
   task rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 d = RDATA_O;
      @(posedge CLK_I);
   endtask

   // One-cycle halt (1) or clear-watchdog (0) instruction pulse.
   task strobe(input bit h);
      @(posedge CLK_I);
      if (h)
         HALT_I <= 1'b1;
      else
         CLEAR_WATCHDOG_INSTRUCTION_I <= 1'b1;
      @(posedge CLK_I);
      HALT_I <= 1'b0;
      CLEAR_WATCHDOG_INSTRUCTION_I <= 1'b0;
      #1;
   endtask

   // Waits for action pulse k; running out of the bound ends the run.
   task wait_act(input int k, input int lim, output int n);
      n = 0;
      do
      begin
         @(posedge CLK_I);
         #1 n++;
      end
      while (act[k] !== 1'b1 && n < lim);
      if (act[k] !== 1'b1)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, act,
            4'(1 << k));
         stop_test;
      end
   endtask

   // Main sequence: reset values, mode table, then watchdog cases.
   initial
   begin
      int n;
      logic [7:0] d;
      tick(10);
      NRST_I <= 1'b1;
      for (int a = 0; a < 6; a++)
      begin
         rd(a[2:0], d);
         check(d, (a == 2) ? WDOG_CTRL_RST : 8'h00);
      end
      wr(OFS_PA_WAKE, 8'h04);
      foreach (rows[i])
      begin
         wr(OFS_SYSTEM_MODE, rows[i].mode_v);
         wr(OFS_CTRL, rows[i].ctrl_v);
         IRQ_EN_I <= rows[i].en;
         STACK_FULL_I <= rows[i].full;
         IRQ_REQ_I <= 4'h1;
         tick(2);
         strobe(1);
         check(gates, rows[i].gate);
         rd(OFS_STATUS, d);
         check(d, rows[i].st);
         PORT_A_I[5] <= 1'b0;
         tick(60);
         check(gates, rows[i].gate);
         if (rows[i].port)
            PORT_A_I[2] <= 1'b0;
         else
            IRQ_REQ_I[1] <= 1'b1;
         wait_act(rows[i].k, 300, n);
         check(gates, 8'h06);
         rd(OFS_SYSTEM_MODE, d);
         check(d, rows[i].mode_v);
         PORT_A_I <= 8'hFF;
         IRQ_REQ_I <= 4'h0;
         tick(8);
      end
      // Overflow while asleep after 2^8 sub ticks from the halt.
      wr(OFS_WDOG_CTRL, 8'h50);
      strobe(1);
      wait_act(2, 3000, n);
      check(8'(n > 2030 && n < 2080), 8'h01);
      rd(OFS_STATUS, d);
      check(d, 8'h03);
      rd(OFS_WDOG_CTRL, d);
      check(d, 8'h50);
      // Regular clears keep the watchdog from firing in run.
      repeat (3)
      begin
         tick(1500);
         strobe(0);
      end
      check(8'(dev_cnt), 8'h00);
      rd(OFS_STATUS, d);
      check(d & 8'h01, 8'h00);
      wait_act(3, 2200, n);
      rd(OFS_STATUS, d);
      check(d & 8'h02, 8'h02);
      // An illegal enable code resets after the debounce and reloads.
      wr(OFS_WDOG_CTRL, 8'h00);
      wait_act(3, 60, n);
      // Two to three sub clock periods of eight core cycles each.
      check(8'(n > 16 && n < 25), 8'h01);
      rd(OFS_WDOG_CTRL, d);
      check(d, WDOG_CTRL_RST);
      // A second reset in mid-run reloads the control register.
      wr(OFS_WDOG_CTRL, 8'h51);
      NRST_I <= 1'b0;
      tick(2);
      NRST_I <= 1'b1;
      rd(OFS_WDOG_CTRL, d);
      check(d, WDOG_CTRL_RST);
      stop_test;
   end
endmodule

`default_nettype wire
